/* File: mop_pkg.sv */
// How it works
// - primary rated current accepted up to 500 A small or 3600 A large models.
// - primary rated current of zero disables motor channel while the secondary is not the reference; switch channel stays armed.
// - secondary rated current resets to 9999, which marks the second channel invalid.
// - second function select makes the secondary rated current the motor reference.
// - second function select sits on terminal zero; code 3 moves it elsewhere.
// - heat at 85 percent raises overload alarm and prealarm display.
// - heat at 100 percent trips and records motor or switch trip code.
// - the alarm alone never stops the drive.
// - alarm reaches a terminal only with code 8 high or 108 low.
// - trip and heat clear only by power-on reset or drive reset input; motor heat also clears while the motor reference is zero.
// - constant-torque type 1 keeps full continuous rating from 6 Hz upward.
// - higher carrier frequency selection shortens switch overload time.
// - switch load percent is motor current over drive rated current times 100.
// - in IPM motor control a trip halts the output switches.
// - IPM initialisation loads the IPM rated current into the primary setting.
// - overload is monitored continuously and trips when the curve is exceeded.
// - secondary setting writable only while user group read select is 0.
package mop_pkg;
  // register word addresses
  localparam logic [3:0] REG_PRI = 4'h0;
  localparam logic [3:0] REG_SEC = 4'h1;
  localparam logic [3:0] REG_MTYPE = 4'h2;
  localparam logic [3:0] REG_CARRIER = 4'h3;
  localparam logic [3:0] REG_UGRP = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  localparam logic [3:0] REG_INFUNC = 4'h6;
  localparam logic [3:0] REG_OUTFUNC = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MHEAT = 4'h9;
  localparam logic [3:0] REG_LOAD = 4'ha;
  localparam logic [3:0] REG_IRQ_ST = 4'hb;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  // values after reset
  localparam logic [11:0] RST_PRI = 12'h064;
  localparam logic [13:0] SEC_INVALID = 14'h270f;
  localparam logic [31:0] RST_INFUNC = 32'h00000003;
  localparam logic [31:0] RST_OUTFUNC = 32'h00000008;
  // setting limits and codes
  localparam logic [11:0] MAX_SMALL = 12'h1f4;
  localparam logic [11:0] MAX_LARGE = 12'he10;
  localparam logic [7:0] MTYPE_CT = 8'h01;
  localparam logic [7:0] MTYPE_IPM_A = 8'h78;
  localparam logic [7:0] MTYPE_IPM_B = 8'hd2;
  localparam logic [7:0] CODE_SECOND_FN = 8'h03;
  localparam logic [7:0] CODE_ALARM_POS = 8'h08;
  localparam logic [7:0] CODE_ALARM_NEG = 8'h6c;
  localparam logic [7:0] TRIP_NONE = 8'h00;
  localparam logic [7:0] TRIP_MOTOR = 8'h10;
  localparam logic [7:0] TRIP_SWITCH = 8'h11;
  // frequency in units of 0.1 Hz
  localparam logic [15:0] CT_MIN_FREQ = 16'h003c;
  localparam logic [15:0] LOW_FREQ = 16'h012c;
  // thresholds in percent of the trip level
  localparam logic [39:0] PRE_PCT = 40'h55;
  localparam logic [39:0] FULL_PCT = 40'h64;
  // heat capacity in ticks per unit of rated power
  localparam logic [7:0] MOTOR_K = 8'h3c;
  localparam logic [7:0] SW_K = 8'h50;
  localparam logic [7:0] SW_STEP = 8'h02;
  // integration tick
  localparam int TICK_US = 1000;
  localparam int CLK_MHZ = 40;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // interrupt bits
  localparam int IRQ_PRE = 0;
  localparam int IRQ_MTRIP = 1;
  localparam int IRQ_STRIP = 2;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 4;
  typedef enum logic [1:0] {
    MOP_ST_RUN = 2'b01,
    MOP_ST_TRIP = 2'b10
  } mop_state_e;
endpackage

/* File: mop_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module mop_tick #(
  parameter int TICK_CYC = 40000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  output logic tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mop_tick_s;
  mop_tick_s s_reg;
  mop_tick_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == 32'(TICK_CYC - 1)) begin
      s_next.cnt = 32'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;

  a_tick_single: assert property (@(posedge clk_i) disable iff (reset_i)
    tick_o |=> !tick_o) else $error("tick longer than one cycle");
endmodule
`default_nettype wire

/* File: mop_heat.sv */
`timescale 1ns/1ps
`default_nettype none
module mop_heat (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic enable_i,
  input wire logic [11:0] cur_i,
  input wire logic [11:0] ref_i,
  input wire logic [7:0] k_i,
  output logic pre_o,
  output logic full_o,
  output logic [31:0] heat_o
);
  typedef struct packed {
    logic [31:0] acc;
    logic pre;
    logic full;
  } mop_heat_s;
  mop_heat_s s_reg;
  mop_heat_s s_next;
  logic [23:0] i2;
  logic [23:0] r2;
  logic [31:0] thr;
  logic [32:0] sum;
  logic [39:0] a100;

  always_comb begin
    i2 = cur_i * cur_i;
    r2 = ref_i * ref_i;
    thr = r2 * k_i;
    sum = {1'b0, s_reg.acc} + {9'h0, i2 - r2};
    s_next = s_reg;
    if (clear_i || !enable_i) begin
      s_next.acc = 32'h0;
    end else if (tick_i) begin
      // i squared against rating squared gives an inverse-time curve
      if (i2 > r2) begin
        s_next.acc = (sum > {1'b0, thr}) ? thr : sum[31:0];
      end else if (s_reg.acc > {8'h0, r2 - i2}) begin
        s_next.acc = s_reg.acc - {8'h0, r2 - i2};
      end else begin
        s_next.acc = 32'h0;
      end
    end
    a100 = s_next.acc * 40'h64;
    s_next.pre = enable_i && thr != 32'h0 &&
                 a100 >= thr * mop_pkg::PRE_PCT;
    s_next.full = enable_i && thr != 32'h0 &&
                  a100 >= thr * mop_pkg::FULL_PCT;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pre_o = s_reg.pre;
  assign full_o = s_reg.full;
  assign heat_o = s_reg.acc;

  a_full_pre: assert property (@(posedge clk_i) disable iff (reset_i)
    full_o |-> pre_o) else $error("full without prealarm");
  a_clear_heat: assert property (@(posedge clk_i) disable iff (reset_i)
    clear_i |=> heat_o == 32'h0 && !full_o) else $error("heat kept");
endmodule
`default_nettype wire

/* File: mop_overload.sv */
`timescale 1ns/1ps
`default_nettype none
module mop_overload #(
  parameter int TICK_CYC = mop_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [11:0] current_i,
  input wire logic [11:0] inv_rated_i,
  input wire logic [15:0] freq_i,
  input wire logic large_model_i,
  input wire logic drive_reset_i,
  input wire logic [3:0] in_term_i,
  input wire logic [11:0] ipm_rated_i,
  output logic [3:0] out_term_o,
  output logic overload_alarm_output_o,
  output logic overload_prealarm_display_o,
  output logic trip_o,
  output logic switch_halt_o,
  output logic [7:0] trip_code_o,
  output logic irq_o
);
  typedef struct packed {
    mop_pkg::mop_state_e state;
    logic [11:0] pri;
    logic [13:0] sec;
    logic [7:0] mtype;
    logic [3:0] carrier;
    logic [7:0] ugrp;
    logic [31:0] infunc;
    logic [31:0] outfunc;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic alarm;
    logic [3:0] out_term;
    logic [7:0] code;
    logic halt;
    logic irq;
    // trip kept in a flop of its own so the pin never sees a decode glitch
    logic trip;
  } mop_top_s;

  mop_top_s s_reg;
  mop_top_s s_next;
  logic tick;
  logic m_pre;
  logic m_full;
  logic s_pre;
  logic s_full;
  logic [31:0] m_heat;
  logic [31:0] s_heat;
  logic sec_fn;
  logic use_sec;
  logic motor_en;
  logic ipm;
  logic [11:0] max_cur;
  logic [11:0] ref_raw;
  logic [11:0] ref_eff;
  logic [15:0] knee;
  logic [7:0] sw_k;
  logic [19:0] load_num;
  logic [15:0] load_pct;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [7:0] ofn;

  //////////////////////////////////////////////////////////////////////////
  // reference selection and derating

  always_comb begin
    sec_fn = 1'b0;
    for (int k = 0; k < mop_pkg::NUM_IN; k++) begin
      if (s_reg.infunc[8*k +: 8] == mop_pkg::CODE_SECOND_FN &&
          in_term_i[k]) begin
        sec_fn = 1'b1;
      end
    end
    use_sec = sec_fn && s_reg.sec != mop_pkg::SEC_INVALID;
    ref_raw = use_sec ? s_reg.sec[11:0] : s_reg.pri;
    motor_en = ref_raw != 12'h000;
    // constant-torque motors cool well down to the lower knee
    knee = (s_reg.mtype == mop_pkg::MTYPE_CT) ?
           mop_pkg::CT_MIN_FREQ : mop_pkg::LOW_FREQ;
    ref_eff = (freq_i < knee) ?
              ref_raw - {2'h0, ref_raw[11:2]} : ref_raw;
    // less heat capacity at higher carrier means shorter trip time
    sw_k = 8'(mop_pkg::SW_K - 8'(s_reg.carrier * mop_pkg::SW_STEP));
    ipm = s_reg.mtype == mop_pkg::MTYPE_IPM_A ||
          s_reg.mtype == mop_pkg::MTYPE_IPM_B;
    max_cur = large_model_i ? mop_pkg::MAX_LARGE : mop_pkg::MAX_SMALL;
    load_num = current_i * 20'h64;
    load_pct = (inv_rated_i == 12'h000) ? 16'h0 :
               16'(load_num / {8'h0, inv_rated_i});
  end

  mop_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  // both channels accumulate, also while tripped; the motor channel holds zero heat while its reference is zero
  mop_heat u_motor (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .clear_i(drive_reset_i),
    .enable_i(motor_en),
    .cur_i(current_i),
    .ref_i(ref_eff),
    .k_i(mop_pkg::MOTOR_K),
    .pre_o(m_pre),
    .full_o(m_full),
    .heat_o(m_heat)
  );

  // switch channel is referenced to the drive rating, never disabled
  mop_heat u_switch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .clear_i(drive_reset_i),
    .enable_i(1'b1),
    .cur_i(current_i),
    .ref_i(inv_rated_i),
    .k_i(sw_k),
    .pre_o(s_pre),
    .full_o(s_full),
    .heat_o(s_heat)
  );

  //////////////////////////////////////////////////////////////////////////
  // trip state, alarm, registers

  always_comb begin
    s_next = s_reg;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    ofn = 8'h0;
    unique case (s_reg.state)
      mop_pkg::MOP_ST_RUN: begin
        // the alarm does not enter here, only a full channel does
        if (m_full) begin
          s_next.state = mop_pkg::MOP_ST_TRIP;
          s_next.code = mop_pkg::TRIP_MOTOR;
          irq_set[mop_pkg::IRQ_MTRIP] = 1'b1;
        end else if (s_full) begin
          s_next.state = mop_pkg::MOP_ST_TRIP;
          s_next.code = mop_pkg::TRIP_SWITCH;
          irq_set[mop_pkg::IRQ_STRIP] = 1'b1;
        end
      end
      mop_pkg::MOP_ST_TRIP: begin
        // register writes cannot release a trip
        if (drive_reset_i) begin
          s_next.state = mop_pkg::MOP_ST_RUN;
          s_next.code = mop_pkg::TRIP_NONE;
        end
      end
      default: begin
        s_next.state = mop_pkg::MOP_ST_TRIP;
        s_next.code = mop_pkg::TRIP_MOTOR;
      end
    endcase
    s_next.halt = ipm && s_next.state == mop_pkg::MOP_ST_TRIP;
    s_next.trip = s_next.state == mop_pkg::MOP_ST_TRIP;
    s_next.alarm = m_pre || s_pre ||
                   s_next.state == mop_pkg::MOP_ST_TRIP;
    if (s_next.alarm && !s_reg.alarm) begin
      irq_set[mop_pkg::IRQ_PRE] = 1'b1;
    end
    for (int j = 0; j < mop_pkg::NUM_OUT; j++) begin
      ofn = s_reg.outfunc[8*j +: 8];
      s_next.out_term[j] = (ofn == mop_pkg::CODE_ALARM_POS) ? s_next.alarm :
                           (ofn == mop_pkg::CODE_ALARM_NEG) ? !s_next.alarm :
                           1'b0;
    end
    if (wr_i) begin
      unique case (addr_i)
        mop_pkg::REG_PRI: begin
          if (wdata_i[31:12] == 20'h0 && wdata_i[11:0] <= max_cur) begin
            s_next.pri = wdata_i[11:0];
          end
        end
        mop_pkg::REG_SEC: begin
          if (s_reg.ugrp == 8'h00 && wdata_i[31:14] == 18'h0 &&
              (wdata_i[13:0] == mop_pkg::SEC_INVALID ||
               wdata_i[13:0] <= {2'h0, max_cur})) begin
            s_next.sec = wdata_i[13:0];
          end
        end
        mop_pkg::REG_MTYPE: s_next.mtype = wdata_i[7:0];
        mop_pkg::REG_CARRIER: s_next.carrier = wdata_i[3:0];
        mop_pkg::REG_UGRP: s_next.ugrp = wdata_i[7:0];
        mop_pkg::REG_CTRL: begin
          if (wdata_i[0]) begin
            s_next.pri = ipm_rated_i;
          end
        end
        mop_pkg::REG_INFUNC: s_next.infunc = wdata_i;
        mop_pkg::REG_OUTFUNC: s_next.outfunc = wdata_i;
        mop_pkg::REG_IRQ_ST: irq_clr = wdata_i[2:0];
        mop_pkg::REG_IRQ_MASK: s_next.irq_mask = wdata_i[2:0];
        default: begin
        end
      endcase
    end
    // a new event in the clearing cycle stays pending
    s_next.irq_st = (s_reg.irq_st & ~irq_clr) | irq_set;
    s_next.irq = |(s_next.irq_st & s_next.irq_mask);
    s_next.rdata = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        mop_pkg::REG_PRI: s_next.rdata = {20'h0, s_reg.pri};
        mop_pkg::REG_SEC: s_next.rdata = {18'h0, s_reg.sec};
        mop_pkg::REG_MTYPE: s_next.rdata = {24'h0, s_reg.mtype};
        mop_pkg::REG_CARRIER: s_next.rdata = {28'h0, s_reg.carrier};
        mop_pkg::REG_UGRP: s_next.rdata = {24'h0, s_reg.ugrp};
        mop_pkg::REG_INFUNC: s_next.rdata = s_reg.infunc;
        mop_pkg::REG_OUTFUNC: s_next.rdata = s_reg.outfunc;
        mop_pkg::REG_STATUS: begin
          s_next.rdata = {16'h0, s_reg.code, 2'h0, use_sec, s_pre,
                          m_pre, s_reg.halt, s_reg.alarm,
                          s_reg.state == mop_pkg::MOP_ST_TRIP};
        end
        mop_pkg::REG_MHEAT: s_next.rdata = m_heat;
        mop_pkg::REG_LOAD: s_next.rdata = {16'h0, load_pct};
        mop_pkg::REG_IRQ_ST: s_next.rdata = {29'h0, s_reg.irq_st};
        mop_pkg::REG_IRQ_MASK: s_next.rdata = {29'h0, s_reg.irq_mask};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.state <= mop_pkg::MOP_ST_RUN;
      s_reg.pri <= mop_pkg::RST_PRI;
      s_reg.sec <= mop_pkg::SEC_INVALID;
      s_reg.infunc <= mop_pkg::RST_INFUNC;
      s_reg.outfunc <= mop_pkg::RST_OUTFUNC;
      s_reg.code <= mop_pkg::TRIP_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign out_term_o = s_reg.out_term;
  assign overload_alarm_output_o = s_reg.alarm;
  assign overload_prealarm_display_o = s_reg.alarm;
  assign trip_o = s_reg.trip;
  assign switch_halt_o = s_reg.halt;
  assign trip_code_o = s_reg.code;
  assign irq_o = s_reg.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_trip_latched: assert property (
    trip_o && !drive_reset_i |=> trip_o && $stable(trip_code_o))
    else $error("trip released without reset");
  a_alarm_no_trip: assert property (
    !trip_o && !m_full && !s_full |=> !trip_o)
    else $error("trip without full heat");
  a_trip_on_full: assert property (
    !trip_o && m_full |=> trip_o && trip_code_o == mop_pkg::TRIP_MOTOR)
    else $error("motor trip missed");
  a_alarm_drop: assert property (
    !m_pre && !s_pre && !trip_o ##1 !trip_o |-> !overload_alarm_output_o)
    else $error("alarm held below threshold");
  a_ipm_halt: assert property (
    trip_o && ipm |=> switch_halt_o || !trip_o)
    else $error("switches not halted");
  a_sec_locked: assert property (
    wr_i && addr_i == mop_pkg::REG_SEC && s_reg.ugrp != 8'h00
    |=> $stable(s_reg.sec)) else $error("secondary written while locked");
  a_pri_zero: assert property (
    s_reg.pri == 12'h000 && !use_sec ##1 s_reg.pri == 12'h000 && !use_sec
    |=> !m_pre) else $error("motor channel active at zero");
  a_out_neg: assert property (
    s_reg.outfunc[7:0] == mop_pkg::CODE_ALARM_NEG && $stable(s_reg.outfunc)
    |-> out_term_o[0] != overload_alarm_output_o)
    else $error("negative alarm terminal wrong");
  a_irq_level: assert property (
    irq_o == |(s_reg.irq_st & s_reg.irq_mask))
    else $error("interrupt level wrong");
  a_rdata_slot: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0) else $error("read data outside slot");
  a_pos_term: assert property (
    s_reg.outfunc[7:0] == mop_pkg::CODE_ALARM_POS && $stable(s_reg.outfunc)
    |-> out_term_o[0] == overload_alarm_output_o)
    else $error("positive alarm terminal wrong");
  a_term_off: assert property (
    s_reg.outfunc[15:8] != mop_pkg::CODE_ALARM_POS &&
    s_reg.outfunc[15:8] != mop_pkg::CODE_ALARM_NEG && $stable(s_reg.outfunc)
    |-> !out_term_o[1]) else $error("unassigned terminal driven");
  a_halt_trip: assert property (
    switch_halt_o |-> trip_o) else $error("switches halted without trip");
  a_display_same: assert property (
    overload_prealarm_display_o == overload_alarm_output_o)
    else $error("prealarm display differs from alarm");
  a_alarm_on_pre: assert property (
    m_pre || s_pre |=> overload_alarm_output_o)
    else $error("alarm missed at prealarm level");
  a_switch_trip: assert property (
    !trip_o && !m_full && s_full
    |=> trip_o && trip_code_o == mop_pkg::TRIP_SWITCH)
    else $error("switch trip missed");
  a_code_idle: assert property (
    !trip_o |-> trip_code_o == mop_pkg::TRIP_NONE)
    else $error("trip code without trip");
  a_ipm_init: assert property (
    wr_i && addr_i == mop_pkg::REG_CTRL && wdata_i[0]
    |=> s_reg.pri == $past(ipm_rated_i)) else $error("rating not loaded");
  a_pri_refuse: assert property (
    wr_i && addr_i == mop_pkg::REG_PRI && wdata_i[11:0] > max_cur
    |=> $stable(s_reg.pri)) else $error("rating above limit taken");
  a_motor_off: assert property (
    !motor_en |=> m_heat == 32'h0) else $error("motor heat at zero rating");
  a_reset_heat: assert property (
    drive_reset_i |=> m_heat == 32'h0 && s_heat == 32'h0)
    else $error("heat kept over reset input");
  a_trip_alarm: assert property (
    trip_o |-> overload_alarm_output_o) else $error("alarm dropped in trip");
  a_rd_pri: assert property (
    rd_i && addr_i == mop_pkg::REG_PRI
    |=> rdata_o == {20'h0, $past(s_reg.pri)}) else $error("rating read wrong");
  a_alarm_irq: assert property (
    !overload_alarm_output_o ##1 overload_alarm_output_o
    |-> s_reg.irq_st[mop_pkg::IRQ_PRE]) else $error("alarm rise not flagged");
endmodule
`default_nettype wire

/* File: mop_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mop_motor_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [11:0] demand_i,
  input wire logic [15:0] speed_i,
  input wire logic halt_i,
  output logic [11:0] current_o,
  output logic [15:0] freq_o
);
  // the winding current follows the demand one cycle late
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      current_o <= 12'h000;
      freq_o <= 16'h0000;
    end else if (halt_i) begin
      // switches off: no current flows, the frequency drops to zero at once
      current_o <= 12'h000;
      freq_o <= 16'h0000;
    end else begin
      current_o <= demand_i;
      freq_o <= speed_i;
    end
  end
endmodule
`default_nettype wire

/* File: test_mop_overload.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mop_overload;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [11:0] current_i;
  logic [11:0] inv_rated_i = 12'h190;
  logic [15:0] freq_i;
  logic large_model_i = 1'b0;
  logic drive_reset_i = 1'b0;
  logic [3:0] in_term_i = 4'h0;
  logic [11:0] ipm_rated_i = 12'h064;
  logic [3:0] out_term_o;
  logic alarm;
  logic pre_disp;
  logic trip_o;
  logic switch_halt_o;
  logic [7:0] trip_code_o;
  logic irq_o;
  logic [11:0] demand = 12'h000;
  logic [15:0] speed = 16'h0258;
  logic [31:0] rd;
  int errors = 0;
  int compares = 0;

  always #12.5 clk_i = ~clk_i;

  mop_motor_model motor_u (.clk_i(clk_i), .reset_i(reset_i),
    .demand_i(demand), .speed_i(speed), .halt_i(switch_halt_o),
    .current_o(current_i), .freq_o(freq_i));

  // a short tick keeps each heating run to a few hundred cycles
  mop_overload #(.TICK_CYC(4)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .current_i(current_i), .inv_rated_i(inv_rated_i),
    .freq_i(freq_i), .large_model_i(large_model_i),
    .drive_reset_i(drive_reset_i), .in_term_i(in_term_i),
    .ipm_rated_i(ipm_rated_i), .out_term_o(out_term_o),
    .overload_alarm_output_o(alarm),
    .overload_prealarm_display_o(pre_disp), .trip_o(trip_o),
    .switch_halt_o(switch_halt_o), .trip_code_o(trip_code_o),
    .irq_o(irq_o));

  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd = rdata_o;
  endtask

  task automatic rchk(input string what, input logic [3:0] a,
                      input logic [31:0] exp);
    rdr(a);
    chk(what, exp, rd);
  endtask

  // w 0 watches the alarm, w 1 the trip
  task automatic wait_for(input int w, input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      #1;
      if ((w == 0 ? alarm : trip_o) === v) return;
    end
    errors++;
    $display("[ERR] wait %0d expected %b seen timeout", w, v);
    report_and_stop();
  endtask

  task automatic clr;
    @(posedge clk_i);
    demand <= 12'h000;
    drive_reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    drive_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("trip clr", 32'h0, {31'h0, trip_o});
    rchk("heat clr", mop_pkg::REG_MHEAT, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic sc_reset_limits;
    rchk("pri rst", mop_pkg::REG_PRI, 32'h64);
    rchk("sec rst", mop_pkg::REG_SEC, 32'h270f);
    rchk("infunc rst", mop_pkg::REG_INFUNC, 32'h3);
    rchk("outfunc rst", mop_pkg::REG_OUTFUNC, 32'h8);
    rchk("unmapped", 4'hf, 32'h0);
    wr(mop_pkg::REG_PRI, 32'h1f5);
    rchk("pri 501", mop_pkg::REG_PRI, 32'h64);
    wr(mop_pkg::REG_PRI, 32'h1f4);
    rchk("pri 500", mop_pkg::REG_PRI, 32'h1f4);
    @(posedge clk_i);
    large_model_i <= 1'b1;
    wr(mop_pkg::REG_PRI, 32'he10);
    rchk("pri 3600", mop_pkg::REG_PRI, 32'he10);
    wr(mop_pkg::REG_PRI, 32'he11);
    rchk("pri 3601", mop_pkg::REG_PRI, 32'he10);
    @(posedge clk_i);
    large_model_i <= 1'b0;
    wr(mop_pkg::REG_PRI, 32'h64);
  endtask

  task automatic sc_motor_trip;
    wr(mop_pkg::REG_OUTFUNC, 32'h00006c08);
    wr(mop_pkg::REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_i);
    #1 chk("term idle", 32'h2, {28'h0, out_term_o});
    demand <= 12'h0c8;
    wait_for(0, 1'b1);
    chk("no trip yet", 32'h0, {31'h0, trip_o});
    chk("prealarm", 32'h1, {31'h0, pre_disp});
    @(posedge clk_i);
    #1 chk("term alarm", 32'h1, {28'h0, out_term_o});
    demand <= 12'h000;
    wait_for(0, 1'b0);
    chk("drop trip", 32'h0, {31'h0, trip_o});
    demand <= 12'h0c8;
    wait_for(1, 1'b1);
    repeat (2) @(posedge clk_i);
    #1 chk("code motor", 32'h10, {24'h0, trip_code_o});
    chk("halt std", 32'h0, {31'h0, switch_halt_o});
    chk("irq set", 32'h1, {31'h0, irq_o});
    rdr(mop_pkg::REG_IRQ_ST);
    chk("irq st", 32'h2, rd & 32'h6);
    wr(mop_pkg::REG_IRQ_ST, 32'h7);
    repeat (2) @(posedge clk_i);
    #1 chk("irq clr", 32'h0, {31'h0, irq_o});
    clr();
  endtask

  task automatic sc_switch_only;
    wr(mop_pkg::REG_CARRIER, 32'hf);
    wr(mop_pkg::REG_PRI, 32'h0);
    inv_rated_i <= 12'h064;
    demand <= 12'h0c8;
    // carrier 15 trips by about 75 cycles, carrier 0 needs over 100
    repeat (100) @(posedge clk_i);
    #1 chk("carrier trip", 32'h1, {31'h0, trip_o});
    wait_for(1, 1'b1);
    repeat (2) @(posedge clk_i);
    #1 chk("code switch", 32'h11, {24'h0, trip_code_o});
    rchk("load pct", mop_pkg::REG_LOAD, 32'hc8);
    rdr(mop_pkg::REG_IRQ_ST);
    chk("irq switch", 32'h4, rd & 32'h4);
    clr();
    @(posedge clk_i);
    inv_rated_i <= 12'h190;
  endtask

  task automatic sc_second;
    wr(mop_pkg::REG_PRI, 32'hc8);
    wr(mop_pkg::REG_UGRP, 32'h1);
    wr(mop_pkg::REG_SEC, 32'h32);
    rchk("sec locked", mop_pkg::REG_SEC, 32'h270f);
    @(posedge clk_i);
    in_term_i <= 4'h1;
    demand <= 12'h064;
    repeat (300) @(posedge clk_i);
    #1 chk("sec invalid", 32'h0, {31'h0, alarm});
    rdr(mop_pkg::REG_STATUS);
    chk("sec unused", 32'h0, rd & 32'h20);
    wr(mop_pkg::REG_UGRP, 32'h0);
    wr(mop_pkg::REG_SEC, 32'h32);
    rchk("sec open", mop_pkg::REG_SEC, 32'h32);
    wait_for(1, 1'b1);
    rdr(mop_pkg::REG_STATUS);
    chk("use sec", 32'h20, rd & 32'h20);
    clr();
    wr(mop_pkg::REG_INFUNC, 32'h00030000);
    rdr(mop_pkg::REG_STATUS);
    chk("term0 free", 32'h0, rd & 32'h20);
    @(posedge clk_i);
    in_term_i <= 4'h4;
    rdr(mop_pkg::REG_STATUS);
    chk("term2 sel", 32'h20, rd & 32'h20);
    @(posedge clk_i);
    in_term_i <= 4'h0;
  endtask

  task automatic sc_ipm;
    wr(mop_pkg::REG_MTYPE, 32'h78);
    wr(mop_pkg::REG_CTRL, 32'h1);
    rchk("ipm init", mop_pkg::REG_PRI, 32'h64);
    demand <= 12'h0c8;
    wait_for(1, 1'b1);
    repeat (2) @(posedge clk_i);
    #1 chk("halt ipm", 32'h1, {31'h0, switch_halt_o});
    @(posedge clk_i);
    #1 chk("current off", 32'h0, {20'h0, current_i});
    clr();
  endtask

  // rated current exactly: heat only where the low-speed derate applies
  task automatic sc_low_speed;
    wr(mop_pkg::REG_MTYPE, 32'h0);
    speed <= 16'h00c8;
    demand <= 12'h064;
    wait_for(0, 1'b1);
    clr();
    wr(mop_pkg::REG_MTYPE, 32'h1);
    demand <= 12'h064;
    repeat (300) @(posedge clk_i);
    rchk("ct heat", mop_pkg::REG_MHEAT, 32'h0);
    speed <= 16'h0032;
    wait_for(0, 1'b1);
    clr();
    speed <= 16'h0258;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    sc_reset_limits();
    sc_motor_trip();
    sc_switch_only();
    sc_second();
    sc_ipm();
    sc_low_speed();
    report_and_stop();
  end
endmodule
`default_nettype wire
